// >>> ccds_rc_status.sv
// Completion descriptor status framer: checks each received
// completion against its outstanding request and emits one
// 96-bit descriptor beat per completion or per timeout of an outstanding tag.
// Assumes request, completion and timeout inputs come from
// logic on CORE_CLK; the payload path runs alongside elsewhere.
// A completion and a timeout offered together: the completion
// goes first, so the timeout source must hold its request.
// Completion and timeout tags at or above TAGS are treated as unknown tags; a request tag selects the entry of its low bits.
// A tag must not be reissued before its completed beat is seen;
// a new request simply takes over the entry.
`timescale 1ns/1ps

// Field positions and fixed counts come from the shared header
`include "ccds_params.svh"

module ccds_rc_status #(
  parameter int TAGS = `CCDS_TAGS
) (
  input  wire logic                  CORE_CLK,
  input  wire logic                  RST_N,
  input  wire logic                  REQ_VALID,
  input  wire logic [7:0]            REQ_TAG,
  input  wire logic [15:0]           REQ_RID,
  input  wire logic [2:0]            REQ_TC,
  input  wire logic [2:0]            REQ_ATTR,
  input  wire logic [11:0]           REQ_ADDR,
  input  wire logic [12:0]           REQ_BYTES,
  input  wire ccds_pkg::ccds_kind_t  REQ_KIND,
  input  wire logic                  CPL_VALID,
  output logic                       CPL_READY,
  input  wire logic [7:0]            CPL_TAG,
  input  wire logic [15:0]           CPL_RID,
  input  wire logic [15:0]           CPL_CID,
  input  wire logic [2:0]            CPL_TC,
  input  wire logic [2:0]            CPL_ATTR,
  input  wire logic [2:0]            CPL_STATUS,
  input  wire logic                  CPL_POISON,
  input  wire logic [11:0]           CPL_LADDR,
  input  wire logic [12:0]           CPL_BCNT,
  input  wire logic [10:0]           CPL_DWCNT,
  input  wire logic                  TMO_VALID,
  output logic                       TMO_READY,
  input  wire logic [7:0]            TMO_TAG,
  output logic                       RC_TVALID,
  input  wire logic                  RC_TREADY,
  output logic [`CCDS_DESC_W-1:0]    RC_TDATA
);
  import ccds_pkg::*;

  localparam int IW = $clog2(TAGS);

  // Tag index must fit the 8-bit tag field
  if (TAGS < 2 || TAGS > 256 || (1 << IW) != TAGS) begin : g_chk
    $error("TAGS must be a power of two from 2 to 256");
  end

  // Every field must fit inside the single descriptor beat
  if (`CCDS_DESC_W < `CCDS_F_ATTR + 3) begin : g_chk_w
    $error("descriptor width too small for its fields");
  end

  // Outstanding request table, one entry per tag
  logic [TAGS-1:0] vld_q;
  logic [15:0]     rid_q  [TAGS];
  logic [2:0]      tc_q   [TAGS];
  logic [2:0]      attr_q [TAGS];
  logic [11:0]     addr_q [TAGS];
  logic [12:0]     rem_q  [TAGS];
  ccds_kind_t      kind_q [TAGS];

  // Two-entry output buffer
  logic                    out_v_q;
  logic                    skid_v_q;
  logic                    room_q;
  logic [`CCDS_DESC_W-1:0] out_q;
  logic [`CCDS_DESC_W-1:0] skid_q;

  // Completion lookup
  logic [IW-1:0]   c_idx;
  logic [IW-1:0]   r_idx;
  logic [IW-1:0]   t_idx;
  logic            c_hit;
  logic            t_hit;
  logic            is_io;
  logic            is_mem;
  logic            zlr;
  logic [12:0]     pay;
  logic [12:0]     retb;
  logic [12:0]     rem;
  ccds_kind_t      kind;
  ccds_err_t       err;
  logic            done;
  logic [12:0]     bcnt;
  logic [10:0]     dwcnt;
  logic            cpl_take;
  logic            tmo_take;
  logic            push;
  logic            pop;
  logic [`CCDS_DESC_W-1:0] desc;

  assign c_idx = CPL_TAG[IW-1:0];
  assign r_idx = REQ_TAG[IW-1:0];
  assign t_idx = TMO_TAG[IW-1:0];

  // Tags beyond the table never match
  assign c_hit = ((CPL_TAG >> IW) == 8'h00) && vld_q[c_idx];
  assign t_hit = ((TMO_TAG >> IW) == 8'h00) && vld_q[t_idx];

  assign kind   = kind_q[c_idx];
  assign rem    = rem_q[c_idx];
  assign is_io  = (kind == CCDS_IO_RD) || (kind == CCDS_IO_WR);
  assign is_mem = !is_io;
  // A memory read of zero bytes is the only one with rem 0
  assign zlr    = is_mem && (rem == 13'h0000);

  // Bytes carried now: payload less the start offset; clipped
  // to the bytes still owed so a short last dword cannot make
  // the remaining count wrap below zero
  assign pay  = {CPL_DWCNT, 2'b00}
              - {11'h000, addr_q[c_idx][1:0]};
  assign retb = (pay < rem) ? pay : rem;

  // Timeout waits while a completion is offered
  assign cpl_take = CPL_VALID && room_q;
  assign tmo_take = TMO_VALID && room_q && !CPL_VALID;
  assign push     = cpl_take || (tmo_take && t_hit);
  assign pop      = out_v_q && RC_TREADY;

  // Completion checks, first failing check wins.
  // I/O and zero-length reads carry no running address, so the
  // address and excess-count checks only apply to real reads.
  always_comb begin
    err = CCDS_OK;
    if (!c_hit) begin
      err = CCDS_TAG;
    end else if (CPL_RID  != rid_q[c_idx]
              || CPL_TC   != tc_q[c_idx]
              || CPL_ATTR != attr_q[c_idx]) begin
      err = CCDS_MATCH;
    end else if (CPL_POISON) begin
      err = CCDS_POISON;
    end else if (CPL_STATUS != `CCDS_ST_SC) begin
      err = CCDS_STAT;
    end else if (is_mem && !zlr
              && CPL_LADDR[6:0] != addr_q[c_idx][6:0]) begin
      err = CCDS_ADDR;
    end else if ((kind != CCDS_IO_WR
              && CPL_DWCNT == `CCDS_DW_NONE)
              || (is_mem && !zlr && CPL_BCNT > rem)) begin
      err = CCDS_NODATA;
    end
  end

  // Byte count, dword count and last-completion flag
  always_comb begin
    bcnt  = rem;
    dwcnt = CPL_DWCNT;
    done  = (err != CCDS_OK) || (retb >= rem);
    if (!c_hit) begin
      bcnt = CPL_BCNT;
    end else if (is_io) begin
      bcnt  = `CCDS_BC_IO;
      dwcnt = (kind == CCDS_IO_RD) ? `CCDS_DW_ONE
                                   : `CCDS_DW_NONE;
      done  = 1'b1;
    end else if (zlr) begin
      bcnt  = `CCDS_BC_ZLR;
      dwcnt = `CCDS_DW_ONE;
      done  = 1'b1;
    end
  end

  // Descriptor assembly; timeout beat carries only four fields.
  // A tag-miss beat echoes the header's own address and count,
  // since no table entry exists to supply them.
  always_comb begin
    desc = '0;
    if (cpl_take) begin
      desc[`CCDS_F_LADDR +: 12] = c_hit ? addr_q[c_idx]
                                        : CPL_LADDR;
      desc[`CCDS_F_ERR   +: 4]  = err;
      desc[`CCDS_F_BCNT  +: 13] = bcnt;
      desc[`CCDS_F_LOCK]        = c_hit
                                  && kind == CCDS_LOCK;
      desc[`CCDS_F_DONE]        = done && c_hit;
      desc[`CCDS_F_DWCNT +: 11] = dwcnt;
      desc[`CCDS_F_STAT  +: 3]  = CPL_STATUS;
      desc[`CCDS_F_POISON]      = CPL_POISON;
      desc[`CCDS_F_RID   +: 16] = CPL_RID;
      desc[`CCDS_F_TAG   +: 8]  = CPL_TAG;
      desc[`CCDS_F_CID   +: 16] = CPL_CID;
      desc[`CCDS_F_TC    +: 3]  = CPL_TC;
      desc[`CCDS_F_ATTR  +: 3]  = CPL_ATTR;
    end else begin
      desc[`CCDS_F_ERR   +: 4]  = CCDS_TMO;
      desc[`CCDS_F_DONE]        = 1'b1;
      desc[`CCDS_F_FUNC  +: 8]  = rid_q[t_idx][7:0];
      desc[`CCDS_F_TAG   +: 8]  = TMO_TAG;
    end
  end

  // Valid bit per tag; a new request outranks a release
  for (genvar i = 0; i < TAGS; i++) begin : g_vld
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
        vld_q[i] <= 1'b0;
      end else if (REQ_VALID && r_idx == IW'(i)) begin
        vld_q[i] <= 1'b1;
      end else if (cpl_take && c_hit && done
                && c_idx == IW'(i)) begin
        vld_q[i] <= 1'b0;
      end else if (tmo_take && t_hit
                && t_idx == IW'(i)) begin
        vld_q[i] <= 1'b0;
      end
    end
  end

  // Request parameters and running progress; no reset needed
  // since vld_q guards every read
  always_ff @(posedge CORE_CLK) begin
    if (REQ_VALID) begin
      rid_q[r_idx]  <= REQ_RID;
      tc_q[r_idx]   <= REQ_TC;
      attr_q[r_idx] <= REQ_ATTR;
      addr_q[r_idx] <= REQ_ADDR;
      rem_q[r_idx]  <= REQ_BYTES;
      kind_q[r_idx] <= REQ_KIND;
    end
    // Progress is dropped when a new request reuses the entry
    // in the same cycle; the new request's values must win
    if (cpl_take && c_hit && !done
     && !(REQ_VALID && r_idx == c_idx)) begin
      rem_q[c_idx]  <= rem - retb;
      addr_q[c_idx] <= addr_q[c_idx] + retb[11:0];
    end
  end

  // Output buffer control; room_q mirrors an empty skid slot
  // so that the ready outputs leave a flip-flop directly.
  // Costs one flop over decoding skid_v_q, but keeps the input
  // ready free of any combinational path
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      out_v_q  <= 1'b0;
      skid_v_q <= 1'b0;
      room_q   <= 1'b1;
    end else if (!out_v_q || pop) begin
      if (skid_v_q) begin
        out_v_q  <= 1'b1;
        skid_v_q <= 1'b0;
        room_q   <= 1'b1;
      end else begin
        out_v_q <= push;
      end
    end else if (push) begin
      skid_v_q <= 1'b1;
      room_q   <= 1'b0;
    end
  end

  // Output buffer data; whole descriptor in one beat
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      out_q  <= '0;
      skid_q <= '0;
    end else begin
      if ((!out_v_q || pop) && (skid_v_q || push)) begin
        out_q <= skid_v_q ? skid_q : desc;
      end
      if (out_v_q && !pop && push) begin
        skid_q <= desc;
      end
    end
  end

  // Stream side straight from the head slot
  assign RC_TVALID = out_v_q;
  assign RC_TDATA  = out_q;

  // Both sources share one ready flop; a full skid slot stalls
  // completions and timeouts alike; only a timeout on a tag not outstanding is dropped
  assign CPL_READY = room_q;
  assign TMO_READY = room_q;

endmodule // ccds_rc_status

// >>> ccds_params.svh
// Constants of the completion descriptor status framer.
// Included by ccds_pkg and the framer; holds definitions only.
`ifndef CCDS_PARAMS_SVH
`define CCDS_PARAMS_SVH

// Error code encodings
`define CCDS_ERR_OK      4'h0
`define CCDS_ERR_POISON  4'h1
`define CCDS_ERR_STAT    4'h2
`define CCDS_ERR_NODATA  4'h3
`define CCDS_ERR_MATCH   4'h4
`define CCDS_ERR_ADDR    4'h5
`define CCDS_ERR_TAG     4'h6
`define CCDS_ERR_TMO     4'h9

// Request kinds held per outstanding tag
`define CCDS_KIND_MEM    2'h0
`define CCDS_KIND_LOCK   2'h1
`define CCDS_KIND_IO_RD  2'h2
`define CCDS_KIND_IO_WR  2'h3

// Completion status of a successful completion
`define CCDS_ST_SC       3'h0

// Descriptor field positions (lsb)
`define CCDS_F_LADDR     0
`define CCDS_F_ERR       12
`define CCDS_F_BCNT      16
`define CCDS_F_LOCK      29
`define CCDS_F_DONE      30
`define CCDS_F_DWCNT     32
`define CCDS_F_STAT      43
`define CCDS_F_POISON    46
`define CCDS_F_RID       48
`define CCDS_F_FUNC      48
`define CCDS_F_TAG       64
`define CCDS_F_CID       72
`define CCDS_F_TC        89
`define CCDS_F_ATTR      92

// Fixed byte and dword counts
`define CCDS_BC_IO       13'h0004
`define CCDS_BC_ZLR      13'h0001
`define CCDS_DW_ONE      11'h001
`define CCDS_DW_NONE     11'h000

// Defaults
`define CCDS_TAGS        32
`define CCDS_DESC_W      96

`endif

// >>> ccds_pkg.sv
// Types of the completion descriptor status framer.
// Assumes ccds_params.svh is on the include path.
package ccds_pkg;
  `include "ccds_params.svh"

  // Only these eight codes can ever reach the descriptor
  typedef enum logic [3:0] {
    CCDS_OK     = `CCDS_ERR_OK,
    CCDS_POISON = `CCDS_ERR_POISON,
    CCDS_STAT   = `CCDS_ERR_STAT,
    CCDS_NODATA = `CCDS_ERR_NODATA,
    CCDS_MATCH  = `CCDS_ERR_MATCH,
    CCDS_ADDR   = `CCDS_ERR_ADDR,
    CCDS_TAG    = `CCDS_ERR_TAG,
    CCDS_TMO    = `CCDS_ERR_TMO
  } ccds_err_t;

  typedef enum logic [1:0] {
    CCDS_MEM   = `CCDS_KIND_MEM,
    CCDS_LOCK  = `CCDS_KIND_LOCK,
    CCDS_IO_RD = `CCDS_KIND_IO_RD,
    CCDS_IO_WR = `CCDS_KIND_IO_WR
  } ccds_kind_t;
endpackage

// >>> ccds_rc_status_chk.sv
// Assertions on the descriptor stream of the status framer.
// Bound to ccds_rc_status; sees its ports only.
`timescale 1ns/1ps
module ccds_rc_status_chk (
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  input wire logic        CPL_VALID,
  input wire logic        CPL_READY,
  input wire logic        RC_TVALID,
  input wire logic        RC_TREADY,
  input wire logic [95:0] RC_TDATA
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  logic [3:0] err;
  // Error code of the beat on offer
  assign err = RC_TDATA[15:12];

  property p_err_legal;
    RC_TVALID |-> err inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};
  endproperty
  a_err_legal: assert property (p_err_legal)
    else $error("reserved error code");
  property p_hold;
    RC_TVALID && !RC_TREADY |=> RC_TVALID && $stable(RC_TDATA);
  endproperty
  a_hold: assert property (p_hold)
    else $error("descriptor changed while stalled");
  property p_lat;
    CPL_VALID && CPL_READY && (!RC_TVALID || RC_TREADY) |=> RC_TVALID;
  endproperty
  a_lat: assert property (p_lat)
    else $error("descriptor late");
  property p_miss;
    RC_TVALID && err == 4'h6 |-> !RC_TDATA[30] && !RC_TDATA[29];
  endproperty
  a_miss: assert property (p_miss)
    else $error("tag miss flagged done or locked");
  property p_tmo;
    RC_TVALID && err == 4'h9 |-> RC_TDATA[30] && {RC_TDATA[95:72],
      RC_TDATA[63:56], RC_TDATA[47:31], RC_TDATA[29:16], RC_TDATA[11:0]} == '0;
  endproperty
  a_tmo: assert property (p_tmo)
    else $error("timeout descriptor fields");
  property p_bcnt;
    RC_TVALID |-> RC_TDATA[28:16] <= 13'h1000;
  endproperty
  a_bcnt: assert property (p_bcnt)
    else $error("byte count above limit");
  property p_done;
    RC_TVALID && !(err inside {4'h0, 4'h6}) |-> RC_TDATA[30];
  endproperty
  a_done: assert property (p_done)
    else $error("error end without done bit");
  property p_poison;
    RC_TVALID && RC_TDATA[46] && !(err inside {4'h4, 4'h6}) |-> err == 4'h1;
  endproperty
  a_poison: assert property (p_poison)
    else $error("poisoned completion code");
endmodule // ccds_rc_status_chk

// >>> ccds_user_sink.sv
// User-side receiver of descriptor beats with a stall control.
// Clocked by CORE_CLK; the testbench pops its queue.
`timescale 1ns/1ps
module ccds_user_sink (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        stall,
  input  wire logic        tvalid,
  input  wire logic [95:0] tdata,
  output logic             tready
);
  logic [95:0] got[$];
  // Ready follows stall one edge late, like registered user logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tready <= 1'b0;
    else tready <= !stall;
  end
  // On error only address bits 6:0 are trusted, rest cleared
  always @(posedge clk) begin
    if (rst_n && tvalid && tready) begin
      if (tdata[15:12] != 4'h0)
        got.push_back({tdata[95:12], 5'h00, tdata[6:0]});
      else
        got.push_back(tdata);
    end
  end
endmodule // ccds_user_sink

// >>> completion_descriptor_status_fields_tb_top.sv
// Testbench of the completion descriptor status framer.
// Needs ccds_pkg, ccds_rc_status, its checker and ccds_user_sink.
`timescale 1ns/1ps
module completion_descriptor_status_fields_tb_top;
  import ccds_pkg::*;
  logic        CORE_CLK = 0, RST_N = 0, REQ_VALID = 0, CPL_VALID = 0;
  logic        TMO_VALID = 0, CPL_POISON = 0, stall = 0, ok;
  logic        RC_TREADY, CPL_READY, TMO_READY, RC_TVALID;
  logic [7:0]  REQ_TAG = 0, CPL_TAG = 0, TMO_TAG = 0;
  logic [15:0] REQ_RID = 0, CPL_RID = 0, CPL_CID = 16'h0200;
  logic [2:0]  REQ_TC = 0, REQ_ATTR = 0, CPL_TC = 0, CPL_ATTR = 0;
  logic [2:0]  CPL_STATUS = 0;
  logic [11:0] REQ_ADDR = 0, CPL_LADDR = 0;
  logic [12:0] REQ_BYTES = 0, CPL_BCNT = 0;
  logic [10:0] CPL_DWCNT = 0;
  logic [95:0] RC_TDATA, d;
  ccds_kind_t  REQ_KIND = CCDS_MEM;
  int          error_cnt = 0, compares = 0;

  // 40 MHz core clock
  always #12.5 CORE_CLK = ~CORE_CLK;
  ccds_rc_status #(.TAGS(4)) DUT (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
    .REQ_VALID(REQ_VALID), .REQ_TAG(REQ_TAG), .REQ_RID(REQ_RID),
    .REQ_TC(REQ_TC), .REQ_ATTR(REQ_ATTR), .REQ_ADDR(REQ_ADDR),
    .REQ_BYTES(REQ_BYTES), .REQ_KIND(REQ_KIND), .CPL_VALID(CPL_VALID),
    .CPL_READY(CPL_READY), .CPL_TAG(CPL_TAG), .CPL_RID(CPL_RID),
    .CPL_CID(CPL_CID), .CPL_TC(CPL_TC), .CPL_ATTR(CPL_ATTR),
    .CPL_STATUS(CPL_STATUS), .CPL_POISON(CPL_POISON), .CPL_LADDR(CPL_LADDR),
    .CPL_BCNT(CPL_BCNT), .CPL_DWCNT(CPL_DWCNT), .TMO_VALID(TMO_VALID),
    .TMO_READY(TMO_READY), .TMO_TAG(TMO_TAG), .RC_TVALID(RC_TVALID),
    .RC_TREADY(RC_TREADY), .RC_TDATA(RC_TDATA));
  ccds_user_sink u_sink (.clk(CORE_CLK), .rst_n(RST_N), .stall(stall),
    .tvalid(RC_TVALID), .tdata(RC_TDATA), .tready(RC_TREADY));

  // Inputs move 2 ns after the edge, clear of sampling
  task automatic cyc();
    @(posedge CORE_CLK);
    #2;
  endtask
  task automatic cmp(input string nm, input logic [23:0] e, g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // Requester ID is derived from the tag so timeouts can be checked
  task automatic req(input logic [7:0] t, input ccds_kind_t k,
      input logic [11:0] a, input logic [12:0] b);
    {REQ_TAG, REQ_ADDR, REQ_BYTES, REQ_VALID} = {t, a, b, 1'b1};
    REQ_RID = {13'h0020, t[2:0]};
    REQ_KIND = k;
    cyc();
    REQ_VALID = 0;
  endtask
  // Valid held through refusals; more keeps it up for back to back
  task automatic cpl(input logic [7:0] t, input logic [2:0] s,
      input logic p, input logic [11:0] la, input logic [12:0] bc,
      input logic [10:0] dw, input logic [15:0] x, input logic more);
    {CPL_TAG, CPL_STATUS, CPL_POISON, CPL_LADDR} = {t, s, p, la};
    {CPL_BCNT, CPL_DWCNT, CPL_VALID} = {bc, dw, 1'b1};
    CPL_RID = {13'h0020, t[2:0]} ^ x;
    do begin
      ok = CPL_READY;
      cyc();
    end while (!ok);
    if (!more) CPL_VALID = 0;
  endtask
  task automatic chk(input logic [3:0] e, input logic [12:0] b,
      input logic lk, input logic dn);
    int n = 0;
    while (u_sink.got.size() == 0 && n < 40) begin
      cyc();
      n++;
    end
    d = (u_sink.got.size() > 0) ? u_sink.got.pop_front() : 'x;
    cmp("err_bcnt_lock_done", {e, b, lk, dn},
        {d[15:12], d[28:16], d[29], d[30]});
  endtask

  task automatic s_split();
    req(8'h00, CCDS_MEM, 12'h000, 13'h0100);
    cpl(8'h00, 3'h0, 1'b0, 12'h000, 13'h0100, 11'h020, 16'h0, 1'b1);
    cpl(8'h00, 3'h0, 1'b0, 12'h080, 13'h0080, 11'h020, 16'h0, 1'b0);
    chk(4'h0, 13'h0100, 1'b0, 1'b0);
    chk(4'h0, 13'h0080, 1'b0, 1'b1);
    cmp("laddr", 24'h000080, {12'h000, d[11:0]});
    req(8'h01, CCDS_MEM, 12'h010, 13'h0008);
    cpl(8'h01, 3'h0, 1'b0, 12'h010, 13'h0008, 11'h002, 16'h0, 1'b0);
    chk(4'h0, 13'h0008, 1'b0, 1'b1);
  endtask
  task automatic s_kinds();
    req(8'h02, CCDS_LOCK, 12'h000, 13'h0004);
    cpl(8'h02, 3'h0, 1'b0, 12'h000, 13'h0004, 11'h001, 16'h0, 1'b0);
    chk(4'h0, 13'h0004, 1'b1, 1'b1);
    req(8'h03, CCDS_IO_RD, 12'h000, 13'h0004);
    cpl(8'h03, 3'h0, 1'b0, 12'h000, 13'h0004, 11'h001, 16'h0, 1'b0);
    chk(4'h0, 13'h0004, 1'b0, 1'b1);
    cmp("dwcnt_io_rd", 24'h000001, {13'h0000, d[42:32]});
    req(8'h03, CCDS_IO_WR, 12'h000, 13'h0004);
    cpl(8'h03, 3'h0, 1'b0, 12'h000, 13'h0004, 11'h000, 16'h0, 1'b0);
    chk(4'h0, 13'h0004, 1'b0, 1'b1);
    cmp("dwcnt_io_wr", 24'h000000, {13'h0000, d[42:32]});
    req(8'h00, CCDS_MEM, 12'h040, 13'h0000);
    cpl(8'h00, 3'h0, 1'b0, 12'h040, 13'h0001, 11'h001, 16'h0, 1'b0);
    chk(4'h0, 13'h0001, 1'b0, 1'b1);
    cmp("dwcnt_zlr", 24'h000001, {13'h0000, d[42:32]});
  endtask
  // UR, CRS, CA, poison, ID mismatch, address, no data, excess count
  task automatic s_errs();
    logic [2:0] st[8] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
    logic [3:0] ec[8] = '{4'h2, 4'h2, 4'h2, 4'h1, 4'h4, 4'h5, 4'h3, 4'h3};
    for (int i = 0; i < 8; i++) begin
      req(8'h01, CCDS_MEM, 12'h000, 13'h0008);
      cpl(8'h01, st[i], i == 3, (i == 5) ? 12'h004 : 12'h000,
          (i == 7) ? 13'h0010 : 13'h0008, (i == 6) ? 11'h000 : 11'h002,
          (i == 4) ? 16'h0001 : 16'h0000, 1'b0);
      chk(ec[i], 13'h0008, 1'b0, 1'b1);
    end
  endtask
  task automatic s_tmo();
    req(8'h02, CCDS_MEM, 12'h000, 13'h0040);
    {TMO_TAG, TMO_VALID} = {8'h02, 1'b1};
    do begin
      ok = TMO_READY;
      cyc();
    end while (!ok);
    TMO_VALID = 0;
    chk(4'h9, 13'h0000, 1'b0, 1'b1);
    cmp("tag_func", 24'h020002, d[71:48]);
    // The tag is released now, so a second timeout is dropped
    {TMO_TAG, TMO_VALID} = {8'h02, 1'b1};
    cyc();
    TMO_VALID = 0;
    repeat (3) cyc();
    cmp("tmo_dropped", 24'h0,
        {22'h0, RC_TVALID, u_sink.got.size() != 0});
  endtask
  // Two beats held under stall fill the buffer, then all drain in order
  task automatic s_stall();
    stall = 1;
    cpl(8'h07, 3'h0, 1'b0, 12'h000, 13'h0011, 11'h001, 16'h0, 1'b1);
    cpl(8'h07, 3'h0, 1'b0, 12'h000, 13'h0012, 11'h001, 16'h0, 1'b0);
    cyc();
    cmp("ready_full", 24'h0, {22'h0, CPL_READY, TMO_READY});
    stall = 0;
    cpl(8'h05, 3'h0, 1'b0, 12'h000, 13'h0013, 11'h001, 16'h0, 1'b0);
    chk(4'h6, 13'h0011, 1'b0, 1'b0);
    chk(4'h6, 13'h0012, 1'b0, 1'b0);
    chk(4'h6, 13'h0013, 1'b0, 1'b0);
    cmp("drained", 24'h0, {23'h0, RC_TVALID});
  endtask

  task automatic stop_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge CORE_CLK);
    #2;
    RST_N = 1;
    s_split();
    s_kinds();
    s_errs();
    s_tmo();
    s_stall();
    stop_test();
  end
  // Watchdog well beyond the expected run
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
endmodule // completion_descriptor_status_fields_tb_top

bind ccds_rc_status ccds_rc_status_chk u_chk (.CORE_CLK(CORE_CLK),
  .RST_N(RST_N), .CPL_VALID(CPL_VALID), .CPL_READY(CPL_READY),
  .RC_TVALID(RC_TVALID), .RC_TREADY(RC_TREADY), .RC_TDATA(RC_TDATA));
